// ### core/sfpe_flash_device.sv
// What this block does
// - single-line program: 02H, 12H always 32-bit address
// - four-line program: 32H, 34H always 32-bit address
// - sector erase: 20H, 21H always 32-bit address
// - block erase: 52H/5CH 32KB, D8H/DCH 64KB
// - no program or erase runs unless write enable latch set
// - host holds chip select low whole sequence
// - program: select, opcode, address, data, deselect
// - base opcodes take three or four address bytes
// - 32-bit variants always take four address bytes
// - data wraps inside the addressed page
// - over 256 bytes: last 256 are kept
// - untouched page bytes stay unchanged
// - program runs only if deselect on byte
// - erase runs only if deselect after address
// - in-progress flag high for whole cycle
// - write enable latch cleared by cycle end
// - program into protected page is refused
// - erase of protected region is refused
// - with ECC host writes aligned 8-byte units
// - with ECC each unit once per erase
// - four-line program uses all four pins
// - erase address picks whole sector or block
// - address mode flag selects 32-bit addressing
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module sfpe_flash_device (
	input wire logic ref_clk,
	input wire logic rst,
	sfpe_link_if.dev link,
	input wire logic protectTopBottomSel,
	input wire logic [3:0] protectLevel,
	output logic inProgressFlag,
	output logic writeEnableLatch,
	output logic addressModeFlag,
	output logic memWriteEn,
	output logic [31:0] memWriteAddr,
	output logic [7:0] memWriteData,
	output logic memEraseEn,
	output logic [31:0] memEraseBase,
	output logic [31:0] memEraseBytes
);
	import sfpe_pkg::*;

	typedef struct packed {
		logic sclkMeta;
		logic sclkSync;
		logic sclkLast;
		logic csMeta;
		logic csSync;
		logic csLast;
		logic [3:0] ioMeta;
		logic [3:0] ioSync;
		sfpe_dev_state_t st;
		logic [7:0] opcode;
		logic [7:0] shiftIn;
		logic [3:0] bitCnt;
		logic [2:0] addrCnt;
		logic [2:0] addrNeed;
		logic quad;
		logic isProgram;
		logic gotData;
		logic [31:0] addr;
		logic [7:0] col;
		logic [255:0][7:0] pageBuf;
		logic [255:0] pageValid;
		logic [8:0] idx;
		logic [TIMER_W-1:0] timer;
		logic write_enable_latch;
		logic address_mode_flag;
		logic memWe;
		logic [31:0] memWa;
		logic [7:0] memWd;
		logic memEe;
		logic [31:0] memEb;
		logic [31:0] memEl;
	} sfpe_dev_regs_t;

	sfpe_dev_regs_t r;
	sfpe_dev_regs_t n;

	// protected span sits at the top of the array, or at the bottom when selected
	function automatic logic isProtected(input logic [31:0] base, input logic [31:0] bytes,
		input logic bottom, input logic [3:0] level);
		logic [31:0] span;
		logic [31:0] last;
		span = 32'h0;
		if (level >= PROTECT_FULL_LEVEL)
			span = FLASH_BYTES;
		else if (level != 4'h0)
			span = PROTECT_UNIT_BYTES << (level - 4'h1);
		last = base + bytes - 32'h1;
		if (span == 32'h0)
			return 1'b0;
		return bottom ? (base < span) : (last >= FLASH_BYTES - span);
	endfunction : isProtected

	assign inProgressFlag = (r.st == DEV_PROG_WRITE) || (r.st == DEV_PROG_WAIT) || (r.st == DEV_ERASE_WAIT);
	assign writeEnableLatch = r.write_enable_latch;
	assign addressModeFlag = r.address_mode_flag;
	assign memWriteEn = r.memWe;
	assign memWriteAddr = r.memWa;
	assign memWriteData = r.memWd;
	assign memEraseEn = r.memEe;
	assign memEraseBase = r.memEb;
	assign memEraseBytes = r.memEl;
	// reads are outside this block, so the device never drives the data pins
	assign link.devIoOut = 4'hF;
	assign link.devIoOeN = 4'hF;

	always_comb begin
		logic [7:0] nextByte;
		logic [3:0] cnt;
		logic [31:0] regionBytes;
		logic [31:0] regionBase;
		logic allowed;
		nextByte = 8'h0;
		cnt = 4'h0;
		regionBytes = PAGE_BYTES;
		regionBase = 32'h0;
		allowed = 1'b0;
		n = r;
		n.sclkMeta = link.sclk;
		n.sclkSync = r.sclkMeta;
		n.sclkLast = r.sclkSync;
		n.csMeta = link.csN;
		n.csSync = r.csMeta;
		n.csLast = r.csSync;
		n.ioMeta = link.ioLevel;
		n.ioSync = r.ioMeta;
		n.memWe = 1'b0;
		n.memEe = 1'b0;
		case (r.opcode)
			OP_SECTOR_ERASE_CMD, OP_SECTOR_ERASE_CMD_ADDR32: regionBytes = SECTOR_BYTES;
			OP_SMALL_BLOCK_ERASE_CMD, OP_SMALL_BLOCK_ERASE_CMD_ADDR32: regionBytes = SMALL_BLOCK_BYTES;
			OP_LARGE_BLOCK_ERASE_CMD, OP_LARGE_BLOCK_ERASE_CMD_ADDR32: regionBytes = LARGE_BLOCK_BYTES;
			default: regionBytes = PAGE_BYTES;
		endcase
		regionBase = r.addr & ~(regionBytes - 32'h1);
		allowed = (r.bitCnt == 4'h0) && r.write_enable_latch
			&& !isProtected(regionBase, regionBytes, protectTopBottomSel, protectLevel);
		case (r.st)
			DEV_PROG_WRITE: begin
				// walk the page; only bytes the host sent reach the array
				n.memWe = r.pageValid[r.idx[7:0]];
				n.memWa = regionBase | {24'h0, r.idx[7:0]};
				n.memWd = r.pageBuf[r.idx[7:0]];
				n.idx = r.idx + 9'h1;
				if (r.idx == 9'h0FF) begin
					n.st = DEV_PROG_WAIT;
					n.timer = PROG_CYCLES - TIMER_W'(1);
				end
			end
			DEV_PROG_WAIT, DEV_ERASE_WAIT: begin
				if (r.timer == '0) begin
					n.write_enable_latch = 1'b0;
					// a frame opened during the cycle is dropped whole
					n.st = r.csSync ? DEV_CMD : DEV_IGNORE;
				end else begin
					n.timer = r.timer - TIMER_W'(1);
				end
			end
			default: begin
				if (r.csSync) begin
					n.st = DEV_CMD;
					n.bitCnt = 4'h0;
					n.quad = 1'b0;
					n.gotData = 1'b0;
					if (r.csSync && !r.csLast) begin
						if (r.st == DEV_ERASE_READY && allowed) begin
							n.st = DEV_ERASE_WAIT;
							n.memEe = 1'b1;
							n.memEb = regionBase;
							n.memEl = regionBytes;
							n.timer = ERASE_CYCLES - TIMER_W'(1);
						end else if (r.st == DEV_DATA && r.gotData && allowed) begin
							n.st = DEV_PROG_WRITE;
							n.idx = 9'h0;
						end else if (r.st == DEV_SIMPLE && r.bitCnt == 4'h0) begin
							if (r.opcode == OP_WRITE_ENABLE_CMD)
								n.write_enable_latch = 1'b1;
							else if (r.opcode == OP_ENTER_ADDR32_MODE)
								n.address_mode_flag = 1'b1;
							else if (r.opcode == OP_EXIT_ADDR32_MODE)
								n.address_mode_flag = 1'b0;
						end
					end
				end else if (r.sclkSync && !r.sclkLast && r.st != DEV_IGNORE) begin
					if (r.quad) begin
						nextByte = {r.shiftIn[3:0], r.ioSync};
						cnt = r.bitCnt + 4'h4;
					end else begin
						nextByte = {r.shiftIn[6:0], r.ioSync[0]};
						cnt = r.bitCnt + 4'h1;
					end
					n.shiftIn = nextByte;
					n.bitCnt = (cnt == 4'h8) ? 4'h0 : cnt;
					if (cnt == 4'h8) begin
						case (r.st)
							DEV_CMD: begin
								n.opcode = nextByte;
								n.addr = 32'h0;
								n.addrCnt = 3'h0;
								n.pageValid = '0;
								n.isProgram = nextByte inside {OP_SINGLE_LINE_PAGE_PROGRAM,
									OP_SINGLE_LINE_PAGE_PROGRAM_ADDR32, OP_FOUR_LINE_PAGE_PROGRAM,
									OP_FOUR_LINE_PAGE_PROGRAM_ADDR32};
								n.quad = nextByte inside {OP_FOUR_LINE_PAGE_PROGRAM, OP_FOUR_LINE_PAGE_PROGRAM_ADDR32};
								n.addrNeed = (r.address_mode_flag || nextByte inside {OP_SINGLE_LINE_PAGE_PROGRAM_ADDR32,
									OP_FOUR_LINE_PAGE_PROGRAM_ADDR32, OP_SECTOR_ERASE_CMD_ADDR32,
									OP_SMALL_BLOCK_ERASE_CMD_ADDR32, OP_LARGE_BLOCK_ERASE_CMD_ADDR32}) ? 3'h4 : 3'h3;
								if (n.isProgram || nextByte inside {OP_SECTOR_ERASE_CMD, OP_SECTOR_ERASE_CMD_ADDR32,
									OP_SMALL_BLOCK_ERASE_CMD, OP_SMALL_BLOCK_ERASE_CMD_ADDR32,
									OP_LARGE_BLOCK_ERASE_CMD, OP_LARGE_BLOCK_ERASE_CMD_ADDR32})
									n.st = DEV_ADDR;
								else
									n.st = DEV_SIMPLE;
							end
							DEV_ADDR: begin
								n.addr = {r.addr[23:0], nextByte};
								n.addrCnt = r.addrCnt + 3'h1;
								n.col = nextByte;
								if (r.addrCnt + 3'h1 == r.addrNeed)
									n.st = r.isProgram ? DEV_DATA : DEV_ERASE_READY;
							end
							DEV_DATA: begin
								// later bytes overwrite earlier ones in the same page slot
								n.pageBuf[r.col] = nextByte;
								n.pageValid[r.col] = 1'b1;
								n.col = r.col + 8'h1;
								n.gotData = 1'b1;
							end
							default: n.st = DEV_IGNORE;
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
			r.st <= DEV_CMD;
			r.sclkMeta <= 1'b0;
			r.csMeta <= 1'b1;
			r.csSync <= 1'b1;
			r.csLast <= 1'b1;
		end else begin
			r <= n;
		end
	end
endmodule : sfpe_flash_device
`default_nettype wire

// ### core/sfpe_flash_host.sv
`timescale 1ns/1ns
`default_nettype none
module sfpe_flash_host (
	input wire logic ref_clk,
	input wire logic rst,
	sfpe_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import sfpe_pkg::*;

	typedef struct packed {
		sfpe_host_state_t st;
		logic sclk;
		logic csN;
		logic [2:0] div;
		logic [7:0] shiftOut;
		logic [3:0] bitsLeft;
		logic quad;
		logic [12:0] cmdReg;
		logic [31:0] addrReg;
		logic [2:0] addrLeft;
		logic [31:0] addrShift;
		logic [7:0] holdByte;
		logic holdLast;
		logic holdValid;
		logic lastSent;
		logic [31:0] rdata;
	} sfpe_host_regs_t;

	sfpe_host_regs_t r;
	sfpe_host_regs_t n;
	logic access;
	logic mapped;
	logic tick;

	assign access = psel & penable;
	assign mapped = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_DATA) || (paddr == REG_STATUS);
	// a data write stalls until the previous byte has been taken by the shifter
	assign pready = !(pwrite && paddr == REG_DATA && r.holdValid);
	assign pslverr = access & !mapped;
	assign prdata = r.rdata;
	assign tick = (r.div == SCLK_HALF_CYCLES - 3'h1);

	assign link.csN = r.csN;
	assign link.sclk = r.sclk;
	assign link.hostIoOut = r.quad ? r.shiftOut[7:4] : {3'h7, r.shiftOut[7]};
	assign link.hostIoOeN = r.csN ? 4'hF : (r.quad ? 4'h0 : 4'hE);

	always_comb begin
		n = r;
		n.div = tick ? 3'h0 : r.div + 3'h1;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				REG_CMD: n.rdata = {19'h0, r.cmdReg};
				REG_ADDR: n.rdata = r.addrReg;
				REG_STATUS: n.rdata = {30'h0, r.st == HOST_WAIT_DATA, r.st != HOST_IDLE};
				default: n.rdata = 32'h0;
			endcase
		end
		if (access && pwrite && paddr == REG_ADDR && r.st == HOST_IDLE)
			n.addrReg = pwdata;
		if (access && pwrite && paddr == REG_DATA && !r.holdValid) begin
			n.holdByte = pwdata[7:0];
			n.holdLast = pwdata[DATA_LAST_BIT];
			n.holdValid = 1'b1;
		end
		case (r.st)
			HOST_IDLE: begin
				n.sclk = 1'b0;
				n.csN = 1'b1;
				n.quad = 1'b0;
				if (access && pwrite && paddr == REG_CMD) begin
					n.cmdReg = pwdata[12:0];
					n.csN = 1'b0;
					n.shiftOut = pwdata[7:0];
					n.bitsLeft = 4'h8;
					n.addrLeft = pwdata[CMD_ADDR_BYTES_LSB +: 3];
					n.addrShift = (pwdata[CMD_ADDR_BYTES_LSB +: 3] == 3'h3) ? {r.addrReg[23:0], 8'h00} : r.addrReg;
					n.lastSent = 1'b0;
					n.div = 3'h0;
					n.st = HOST_SHIFT;
				end
			end
			HOST_SHIFT: begin
				if (tick) begin
					if (!r.sclk) begin
						n.sclk = 1'b1;
						n.bitsLeft = r.bitsLeft - (r.quad ? 4'h4 : 4'h1);
					end else begin
						n.sclk = 1'b0;
						if (r.bitsLeft != 4'h0) begin
							n.shiftOut = r.quad ? {r.shiftOut[3:0], 4'h0} : {r.shiftOut[6:0], 1'b0};
						end else if (r.addrLeft != 3'h0) begin
							n.shiftOut = r.addrShift[31:24];
							n.addrShift = {r.addrShift[23:0], 8'h00};
							n.addrLeft = r.addrLeft - 3'h1;
							n.bitsLeft = 4'h8;
							n.quad = r.cmdReg[CMD_QUAD_BIT];
						end else if (r.cmdReg[CMD_HAS_DATA_BIT] && !r.lastSent) begin
							n.st = HOST_WAIT_DATA;
						end else begin
							// chip select rises only on a whole byte
							n.st = HOST_END;
						end
					end
				end
			end
			HOST_WAIT_DATA: begin
				if (r.holdValid) begin
					n.shiftOut = r.holdByte;
					n.lastSent = r.holdLast;
					n.holdValid = 1'b0;
					n.bitsLeft = 4'h8;
					n.quad = r.cmdReg[CMD_QUAD_BIT];
					n.div = 3'h0;
					n.st = HOST_SHIFT;
				end
			end
			HOST_END: begin
				if (tick) begin
					n.csN = 1'b1;
					n.quad = 1'b0;
					n.st = HOST_IDLE;
				end
			end
			default: n.st = HOST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
			r.st <= HOST_IDLE;
			r.csN <= 1'b1;
		end else begin
			r <= n;
		end
	end
endmodule : sfpe_flash_host
`default_nettype wire

// ### core/sfpe_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfpe_link_if;
	logic csN;
	logic sclk;
	logic [3:0] hostIoOut;
	logic [3:0] hostIoOeN;
	logic [3:0] devIoOut;
	logic [3:0] devIoOeN;
	logic [3:0] ioLevel;

	// released lines float high through the board pull-ups
	genvar i;
	for (i = 0; i < 4; i++) begin : g_io
		assign ioLevel[i] = !hostIoOeN[i] ? hostIoOut[i] : (!devIoOeN[i] ? devIoOut[i] : 1'b1);
	end

	modport host (output csN, output sclk, output hostIoOut, output hostIoOeN, input ioLevel);
	modport dev (input csN, input sclk, input ioLevel, output devIoOut, output devIoOeN);
endinterface : sfpe_link_if
`default_nettype wire

// ### core/sfpe_pkg.sv
package sfpe_pkg;
	// opcodes of the program and erase family
	localparam logic [7:0] OP_SINGLE_LINE_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SINGLE_LINE_PAGE_PROGRAM_ADDR32 = 8'h12;
	localparam logic [7:0] OP_FOUR_LINE_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] OP_FOUR_LINE_PAGE_PROGRAM_ADDR32 = 8'h34;
	localparam logic [7:0] OP_SECTOR_ERASE_CMD = 8'h20;
	localparam logic [7:0] OP_SECTOR_ERASE_CMD_ADDR32 = 8'h21;
	localparam logic [7:0] OP_SMALL_BLOCK_ERASE_CMD = 8'h52;
	localparam logic [7:0] OP_SMALL_BLOCK_ERASE_CMD_ADDR32 = 8'h5C;
	localparam logic [7:0] OP_LARGE_BLOCK_ERASE_CMD = 8'hD8;
	localparam logic [7:0] OP_LARGE_BLOCK_ERASE_CMD_ADDR32 = 8'hDC;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_ENTER_ADDR32_MODE = 8'hB7;
	localparam logic [7:0] OP_EXIT_ADDR32_MODE = 8'hE9;

	// array geometry
	localparam logic [31:0] PAGE_BYTES = 32'h0000_0100;
	localparam logic [31:0] SECTOR_BYTES = 32'h0000_1000;
	localparam logic [31:0] SMALL_BLOCK_BYTES = 32'h0000_8000;
	localparam logic [31:0] LARGE_BLOCK_BYTES = 32'h0001_0000;
	localparam logic [31:0] FLASH_BYTES = 32'h0400_0000;
	localparam logic [31:0] PROTECT_UNIT_BYTES = 32'h0001_0000;
	localparam logic [3:0] PROTECT_FULL_LEVEL = 4'hB;

	// self-timed cycles, least times rounded up
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROG_TIME_NS = 100000;
	localparam int ERASE_TIME_NS = 200000;
	localparam int TIMER_W = 12;
	localparam logic [TIMER_W-1:0] PROG_CYCLES = TIMER_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] ERASE_CYCLES = TIMER_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// host serial clock: 4 cycles per half period gives 400 ns
	localparam logic [2:0] SCLK_HALF_CYCLES = 3'h4;

	// host register map and fields
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam int CMD_ADDR_BYTES_LSB = 8;
	localparam int CMD_QUAD_BIT = 11;
	localparam int CMD_HAS_DATA_BIT = 12;
	localparam int DATA_LAST_BIT = 8;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_WAIT_BIT = 1;

	typedef enum logic [3:0] {
		DEV_CMD, DEV_ADDR, DEV_DATA, DEV_ERASE_READY, DEV_SIMPLE, DEV_IGNORE,
		DEV_PROG_WRITE, DEV_PROG_WAIT, DEV_ERASE_WAIT
	} sfpe_dev_state_t;

	typedef enum logic [1:0] {HOST_IDLE, HOST_SHIFT, HOST_WAIT_DATA, HOST_END} sfpe_host_state_t;
endpackage : sfpe_pkg

// ### tb/serial_flash_program_erase_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_program_erase_tb;
	import sfpe_pkg::*;
	typedef struct {logic [7:0] op; logic [2:0] nA; logic q; logic [31:0] a; int n; logic [31:0] b; logic [31:0] s;} sfpe_row_t;
	logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, protectTopBottomSel = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, eBase, eBytes, memWriteAddr, memEraseBase, memEraseBytes;
	logic pready, pslverr, err, ran, inProgressFlag, writeEnableLatch, addressModeFlag, memWriteEn, memEraseEn;
	logic [3:0] protectLevel = 4'h0;
	logic [7:0] memWriteData;
	logic [7:0] wr[logic [31:0]], ex[logic [31:0]];
	int badCount = 0, nTests = 0, nWr, nEr;
	// erase rows have no data bytes; an address-only frame is the erase
	sfpe_row_t rows [10] = '{
		'{8'h02, 3'h3, 1'b0, 32'h0000_01FF, 2, 32'h0, 32'h0},
		'{8'h12, 3'h4, 1'b0, 32'h0123_450F, 3, 32'h0, 32'h0},
		'{8'h32, 3'h3, 1'b1, 32'h0000_0200, 2, 32'h0, 32'h0},
		'{8'h34, 3'h4, 1'b1, 32'h0000_03FE, 3, 32'h0, 32'h0},
		'{8'h20, 3'h3, 1'b0, 32'h0000_1234, 0, 32'h0000_1000, 32'h0000_1000},
		'{8'h21, 3'h4, 1'b0, 32'h0234_5678, 0, 32'h0234_5000, 32'h0000_1000},
		'{8'h52, 3'h3, 1'b0, 32'h0000_ABCD, 0, 32'h0000_8000, 32'h0000_8000},
		'{8'h5C, 3'h4, 1'b0, 32'h0300_FFFF, 0, 32'h0300_8000, 32'h0000_8000},
		'{8'hD8, 3'h3, 1'b0, 32'h0012_3456, 0, 32'h0012_0000, 32'h0001_0000},
		'{8'hDC, 3'h4, 1'b0, 32'h03FF_0001, 0, 32'h03FF_0000, 32'h0001_0000}};

	sfpe_link_if link();
	sfpe_flash_host u_sfpe_flash_host (.ref_clk, .rst, .link, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	sfpe_flash_device u_sfpe_flash_device (.ref_clk, .rst, .link, .protectTopBottomSel, .protectLevel,
		.inProgressFlag, .writeEnableLatch, .addressModeFlag, .memWriteEn, .memWriteAddr, .memWriteData,
		.memEraseEn, .memEraseBase, .memEraseBytes);
	sfpe_properties u_sfpe_properties (.ref_clk, .rst, .csN(link.csN), .sclk(link.sclk),
		.hostIoOut(link.hostIoOut), .devIoOeN(link.devIoOeN), .inProgressFlag, .writeEnableLatch,
		.memWriteEn, .memEraseEn);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// mid-cycle sampling keeps the one-cycle pulses clear of edge races
	always @(negedge ref_clk) begin
		if (memWriteEn === 1'b1) begin
			wr[memWriteAddr] = memWriteData;
			nWr++;
		end
		if (memEraseEn === 1'b1) begin
			eBase = memEraseBase;
			eBytes = memEraseBytes;
			nEr++;
		end
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task print_verdict;
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task hang;
		badCount++;
		$display("ERROR wait expected done seen timeout");
		print_verdict();
	endtask : hang

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// the edge that sees pready high is the one that takes the transfer
		for (k = 0; k < 2000; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				rd = prdata;
				err = pslverr;
				break;
			end
		end
		if (k == 2000) hang();
		psel <= 0;
		penable <= 0;
	endtask : apb

	task idle;
		int k;
		for (k = 0; k < 2000; k++) begin
			apb(0, REG_STATUS, 32'h0);
			if (rd[STATUS_BUSY_BIT] === 1'b0) break;
		end
		if (k == 2000) hang();
	endtask : idle

	task cmd(input logic [7:0] op);
		apb(1, REG_CMD, {24'h0, op});
		idle();
	endtask : cmd

	task run(input logic [7:0] op, input logic [2:0] nA, input logic q, input logic [31:0] a, input int n,
		input logic en);
		int k;
		logic [7:0] d;
		wr.delete();
		ex.delete();
		nWr = 0;
		nEr = 0;
		ran = 0;
		if (en) cmd(OP_WRITE_ENABLE_CMD);
		apb(1, REG_ADDR, a);
		apb(1, REG_CMD, {19'h0, n > 0, q, nA, op});
		for (k = 0; k < n; k++) begin
			d = 8'h5A ^ k[7:0];
			ex[{a[31:8], 8'(a[7:0] + k[7:0])}] = d;
			apb(1, REG_DATA, {23'h0, k == n - 1, d});
		end
		idle();
		for (k = 0; k < 12 && ran !== 1'b1; k++) begin
			@(negedge ref_clk);
			ran = inProgressFlag;
		end
		for (k = 0; ran && inProgressFlag !== 1'b0; k++) begin
			if (k == 6000) hang();
			@(negedge ref_clk);
		end
	endtask : run

	task vprog(input logic ok);
		check("ran", ran, ok);
		check("writes", 32'(nWr), ok ? 32'(ex.size()) : 32'h0);
		check("erases", 32'(nEr), 32'h0);
		if (ok) foreach (ex[k]) check("byte", wr.exists(k) ? {24'h0, wr[k]} : 32'hXXXX_XXXX, {24'h0, ex[k]});
	endtask : vprog

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		repeat (2) @(posedge ref_clk);
		check("flag", inProgressFlag, 32'h0);
		check("wel", writeEnableLatch, 32'h0);
		check("ads", addressModeFlag, 32'h0);
		check("cs", link.csN, 32'h1);
		apb(0, 8'h40, 32'h0);
		check("slverr", err, 32'h1);
		check("unmapped", rd, 32'h0);
		foreach (rows[i]) begin
			run(rows[i].op, rows[i].nA, rows[i].q, rows[i].a, rows[i].n, 1);
			if (rows[i].n > 0) vprog(1);
			else begin
				check("eran", ran, 32'h1);
				check("enum", 32'(nEr), 32'h1);
				check("ebase", eBase, rows[i].b);
				check("esize", eBytes, rows[i].s);
			end
			check("welend", writeEnableLatch, 32'h0);
		end
		run(OP_SINGLE_LINE_PAGE_PROGRAM, 3'h3, 0, 32'h0000_0400, 1, 0);
		vprog(0);
		run(OP_SINGLE_LINE_PAGE_PROGRAM, 3'h3, 0, 32'h0000_0500, 0, 1);
		vprog(0);
		run(OP_SECTOR_ERASE_CMD, 3'h3, 0, 32'h0000_1000, 1, 1);
		vprog(0);
		@(posedge ref_clk);
		protectLevel <= PROTECT_FULL_LEVEL;
		run(OP_SINGLE_LINE_PAGE_PROGRAM, 3'h3, 0, 32'h0000_0600, 1, 1);
		vprog(0);
		run(OP_LARGE_BLOCK_ERASE_CMD, 3'h3, 0, 32'h0000_0000, 0, 1);
		vprog(0);
		@(posedge ref_clk);
		protectLevel <= 4'h0;
		run(OP_SINGLE_LINE_PAGE_PROGRAM, 3'h3, 0, 32'h0000_0710, 258, 1);
		vprog(1);
		cmd(OP_ENTER_ADDR32_MODE);
		repeat (5) @(posedge ref_clk);
		check("ads4", addressModeFlag, 32'h1);
		// one aligned 8-byte unit, written once, so the frame also suits an ECC part
		run(OP_SINGLE_LINE_PAGE_PROGRAM, 3'h4, 0, 32'h0100_0020, 8, 1);
		vprog(1);
		cmd(OP_EXIT_ADDR32_MODE);
		repeat (5) @(posedge ref_clk);
		check("ads3", addressModeFlag, 32'h0);
		cmd(OP_WRITE_ENABLE_CMD);
		repeat (5) @(posedge ref_clk);
		check("wel1", writeEnableLatch, 32'h1);
		print_verdict();
	end
endmodule : serial_flash_program_erase_tb
`default_nettype wire

// ### tb/sfpe_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sfpe_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] hostIoOut,
	input wire logic [3:0] devIoOeN,
	input wire logic inProgressFlag,
	input wire logic writeEnableLatch,
	input wire logic memWriteEn,
	input wire logic memEraseEn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	dev_pins_released_a: assert property (devIoOeN == 4'hF)
		else $error("device drove a data pin");
	clock_idle_a: assert property (csN |-> !sclk)
		else $error("serial clock high while deselected");
	select_setup_a: assert property ($fell(csN) |-> !sclk [*3])
		else $error("serial clock rose too soon after select");
	half_period_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("serial clock high phase not four cycles");
	data_hold_a: assert property (sclk && $past(sclk) |-> $stable(hostIoOut))
		else $error("host data changed while clock high");
	write_in_cycle_a: assert property (memWriteEn |-> inProgressFlag)
		else $error("array write outside busy cycle");
	erase_in_cycle_a: assert property (memEraseEn |-> inProgressFlag)
		else $error("array erase outside busy cycle");
	start_needs_wel_a: assert property ($rose(inProgressFlag) |-> $past(writeEnableLatch))
		else $error("cycle started without write enable");
	start_deselected_a: assert property ($rose(inProgressFlag) |-> csN && $past(csN, 2))
		else $error("cycle started while selected");
	wel_cleared_a: assert property ($fell(inProgressFlag) |-> ##[0:1] !writeEnableLatch)
		else $error("write enable still set after cycle");
	cover property ($rose(inProgressFlag));
	cover property ($fell(csN));
	cover property (memEraseEn);
	cover property (memWriteEn);
endmodule : sfpe_properties
`default_nettype wire
